// ===== logic/lrp_pkg.sv
// Shared constants for the run-permit and fault supervisor link
package lrp_pkg;
  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 50;
  // Power-up self check window
  localparam int CHECK_TIME_NS = 10000;
  localparam int CHECK_CYC = (CHECK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Permit release time of a fault-clear toggle
  localparam int RELEASE_TIME_NS = 1000;
  localparam int RELEASE_CYC = (RELEASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // ----------------------------------------------------------------
  // Device input synchroniser lanes
  // ----------------------------------------------------------------
  localparam int NSYNC = 6;
  localparam int SY_GATE = 0;
  localparam int SY_PERMIT = 1;
  localparam int SY_TEMP = 2;
  localparam int SY_SHUT = 3;
  localparam int SY_REFL = 4;
  localparam int SY_TERM = 5;
  // ----------------------------------------------------------------
  // Controller register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_WIDTH = 8'h04;
  localparam logic [7:0] OFS_PERIOD = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0C;
  localparam logic [7:0] OFS_MASK = 8'h10;
  localparam int CTRL_PERMIT = 0;
  localparam int CTRL_CLEAR = 1;
  localparam int CTRL_GATE_EN = 2;
  localparam int NEVT = 4;
  localparam int EV_STOP = 0;
  localparam int EV_EXCESS = 1;
  localparam int EV_REFL = 2;
  localparam int EV_CLR_DONE = 3;
  localparam int LIVE_LSB = 8;
  localparam logic [15:0] WIDTH_RST = 16'h0000;
  localparam logic [15:0] PERIOD_RST = 16'h0064;
  // ----------------------------------------------------------------
  // Device states, Gray coded along check, idle, run, latch, terminal
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_CHECK = 3'b000,
    ST_IDLE = 3'b001,
    ST_RUN = 3'b011,
    ST_LATCH = 3'b010,
    ST_TERM = 3'b110
  } lrp_state_e;
endpackage

// ===== logic/lrp_link_if.sv
// Real-time port between machine controller and laser supervisor
`timescale 1ns/100ps
interface lrp_link_if;
  logic output_gate_pulse;
  logic run_permit_clear;
  logic latched_stop_flag;
  logic pulse_excess_flag;
  logic reflected_power_flag;

  modport dev
  (
    input output_gate_pulse,
    input run_permit_clear,
    output latched_stop_flag,
    output pulse_excess_flag,
    output reflected_power_flag
  );

  modport ctl
  (
    output output_gate_pulse,
    output run_permit_clear,
    input latched_stop_flag,
    input pulse_excess_flag,
    input reflected_power_flag
  );
endinterface

// ===== logic/lrp_device.sv
// Laser-side supervisor: permit, fault latching, pulse gating and flags
// ----------------------------------------------------------------
// Summary of operation
// - Latched fault holds shutdown until permit reset
// - Controller asserts permit after supply power-up
// - Permit input doubles as fault clear
// - Stop flag raised for every latching fault
// - Disruptive faults corrected without stopping system
// - Disruptive and latching faults on separate lines
// - Power-up check; terminal fault blocks operation
// - Terminal fault shown on stop flag
// - Temperature or shutter fault: immediate latched shutdown
// - Recovery needs cleared fault and permit toggle
// - Output gated by commanded pulse width, period
// - Excess flag when duty limit exceeded
// - Reflected flag on high reflected power
// - Warning flags only within inhibited pulse parts
// - Controller clears by release then reassert
// - Stop flag is active-high fault output
// ----------------------------------------------------------------
`timescale 1ns/100ps
module lrp_device
#(
  parameter logic [15:0] MAX_PULSE_CYC = 16'h03E8,
  parameter logic [15:0] DUTY_ON_COST = 16'h0001,
  parameter logic [15:0] DUTY_OFF_CREDIT = 16'h0001,
  parameter logic [15:0] BUCKET_MAX = 16'h0400,
  parameter int CHECK_CYC = lrp_pkg::CHECK_CYC
)
(
  input wire logic pclk,
  input wire logic presetn,
  lrp_link_if.dev link,
  input wire logic overtemp_in,
  input wire logic shutter_in,
  input wire logic refl_high_in,
  input wire logic terminal_in,
  output logic laser_out,
  output logic run_active
);
  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic [lrp_pkg::NSYNC-1:0] pins;
  logic [lrp_pkg::NSYNC-1:0] sync1;
  logic [lrp_pkg::NSYNC-1:0] sync2;
  logic [lrp_pkg::NSYNC-1:0] sync3;
  logic [lrp_pkg::NSYNC-1:0] clean;
  logic permit_q;
  logic permit_rise;
  logic gate;
  logic latch_src;

  assign pins = {terminal_in, refl_high_in, shutter_in, overtemp_in,
                 link.run_permit_clear, link.output_gate_pulse};

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync1 <= '0;
      sync2 <= '0;
      sync3 <= '0;
      clean <= '0;
    end
    else
    begin
      sync1 <= pins;
      sync2 <= sync1;
      sync3 <= sync2;
      for (int i = 0; i < lrp_pkg::NSYNC; i++)
      begin
        if (sync2[i] == sync3[i])
          clean[i] <= sync3[i];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      permit_q <= 1'b0;
    else
      permit_q <= clean[lrp_pkg::SY_PERMIT];
  end

  assign permit_rise = clean[lrp_pkg::SY_PERMIT] & ~permit_q;
  assign gate = clean[lrp_pkg::SY_GATE];
  assign latch_src = clean[lrp_pkg::SY_TEMP] | clean[lrp_pkg::SY_SHUT];

  // ----------------------------------------------------------------
  // Run state
  // ----------------------------------------------------------------
  lrp_pkg::lrp_state_e state;
  lrp_pkg::lrp_state_e next_state;
  logic [15:0] check_cnt;
  logic check_done;

  assign check_done = (check_cnt == 16'(CHECK_CYC - 1));

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      check_cnt <= '0;
    else if (state == lrp_pkg::ST_CHECK && !check_done)
      check_cnt <= check_cnt + 16'h0001;
  end

  always_comb
  begin
    next_state = state;
    case (state)
      lrp_pkg::ST_CHECK:
      begin
        if (check_done)
          next_state = clean[lrp_pkg::SY_TERM] ? lrp_pkg::ST_TERM : lrp_pkg::ST_IDLE;
      end
      lrp_pkg::ST_IDLE:
      begin
        // no operation without a fresh permit
        if (latch_src)
          next_state = lrp_pkg::ST_LATCH;
        else if (permit_rise)
          next_state = lrp_pkg::ST_RUN;
      end
      lrp_pkg::ST_RUN:
      begin
        if (latch_src)
          next_state = lrp_pkg::ST_LATCH;
        else if (!clean[lrp_pkg::SY_PERMIT])
          next_state = lrp_pkg::ST_IDLE;
      end
      lrp_pkg::ST_LATCH:
      begin
        // clear only by toggle with fault gone
        if (permit_rise && !latch_src)
          next_state = lrp_pkg::ST_RUN;
      end
      lrp_pkg::ST_TERM:
        next_state = lrp_pkg::ST_TERM;
      default:
        next_state = lrp_pkg::ST_CHECK;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state <= lrp_pkg::ST_CHECK;
    else
      state <= next_state;
  end

  // ----------------------------------------------------------------
  // Pulse gating and disruptive protection
  // ----------------------------------------------------------------
  logic [15:0] width_cnt;
  logic [15:0] bucket;
  logic [16:0] bucket_up;
  logic over_width;
  logic duty_over;
  logic excess;
  logic refl;
  logic running;
  logic next_laser;

  assign running = (next_state == lrp_pkg::ST_RUN);
  assign over_width = (width_cnt >= MAX_PULSE_CYC);
  assign duty_over = (bucket >= BUCKET_MAX);
  assign excess = gate & running & (over_width | duty_over);
  assign refl = gate & running & clean[lrp_pkg::SY_REFL];
  assign next_laser = gate & running & ~excess & ~refl;
  assign bucket_up = {1'b0, bucket} + {1'b0, DUTY_ON_COST};

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      width_cnt <= '0;
    else if (!gate)
      width_cnt <= '0;
    else if (!over_width)
      width_cnt <= width_cnt + 16'h0001;
  end

  // duty limit self-corrects: inhibit drains the bucket
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      bucket <= '0;
    else if (next_laser)
      bucket <= (bucket_up > {1'b0, BUCKET_MAX}) ? BUCKET_MAX : bucket_up[15:0];
    else if (bucket > DUTY_OFF_CREDIT)
      bucket <= bucket - DUTY_OFF_CREDIT;
    else
      bucket <= '0;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      laser_out <= 1'b0;
      run_active <= 1'b0;
      link.pulse_excess_flag <= 1'b0;
      link.reflected_power_flag <= 1'b0;
    end
    else
    begin
      laser_out <= next_laser;
      run_active <= running;
      // separate flags, only in inhibited part
      link.pulse_excess_flag <= excess;
      link.reflected_power_flag <= refl;
    end
  end

  // Stop flag rises on the same edge that turns the output off
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      link.latched_stop_flag <= 1'b0;
    else
      // active-high stop for latch or terminal
      link.latched_stop_flag <= (next_state == lrp_pkg::ST_LATCH) ||
                                (next_state == lrp_pkg::ST_TERM);
  end
endmodule

// ===== logic/lrp_ctrl.sv
// Machine-controller end: APB registers, pulse generator, permit toggle
`timescale 1ns/100ps
module lrp_ctrl
#(
  parameter int RELEASE_CYC = lrp_pkg::RELEASE_CYC
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  lrp_link_if.ctl link
);
  // ----------------------------------------------------------------
  // Flag synchronisers
  // ----------------------------------------------------------------
  logic [2:0] fl1;
  logic [2:0] fl2;
  logic [2:0] fl3;
  logic [2:0] flags;
  logic [2:0] flags_q;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      fl1 <= '0;
      fl2 <= '0;
      fl3 <= '0;
      flags <= '0;
      flags_q <= '0;
    end
    else
    begin
      fl1 <= {link.reflected_power_flag, link.pulse_excess_flag, link.latched_stop_flag};
      fl2 <= fl1;
      fl3 <= fl2;
      for (int i = 0; i < 3; i++)
      begin
        if (fl2[i] == fl3[i])
          flags[i] <= fl3[i];
      end
      flags_q <= flags;
    end
  end

  // ----------------------------------------------------------------
  // APB registers
  // ----------------------------------------------------------------
  logic setup;
  logic wr;
  logic mapped;
  logic permit;
  logic gate_en;
  logic [15:0] width;
  logic [15:0] period;
  logic [lrp_pkg::NEVT-1:0] status;
  logic [lrp_pkg::NEVT-1:0] mask;
  logic [lrp_pkg::NEVT-1:0] evt;
  logic [lrp_pkg::NEVT-1:0] next_status;
  logic [15:0] clr_cnt;
  logic clr_busy;
  logic clr_start;
  logic clr_end;

  assign setup = psel & ~penable;
  assign wr = psel & penable & pwrite;
  assign mapped = (paddr == lrp_pkg::OFS_CTRL) || (paddr == lrp_pkg::OFS_WIDTH) ||
                  (paddr == lrp_pkg::OFS_PERIOD) || (paddr == lrp_pkg::OFS_STATUS) ||
                  (paddr == lrp_pkg::OFS_MASK);
  assign clr_start = wr && paddr == lrp_pkg::OFS_CTRL && pwdata[lrp_pkg::CTRL_CLEAR];
  assign clr_end = clr_busy && clr_cnt == 16'h0000;

  function automatic logic [31:0] read_word(input logic [7:0] a);
    logic [31:0] d;
    d = 32'h0000_0000;
    case (a)
      lrp_pkg::OFS_CTRL:
      begin
        d[lrp_pkg::CTRL_PERMIT] = permit;
        d[lrp_pkg::CTRL_CLEAR] = clr_busy;
        d[lrp_pkg::CTRL_GATE_EN] = gate_en;
      end
      lrp_pkg::OFS_WIDTH: d[15:0] = width;
      lrp_pkg::OFS_PERIOD: d[15:0] = period;
      lrp_pkg::OFS_STATUS:
      begin
        d[lrp_pkg::NEVT-1:0] = status;
        d[lrp_pkg::LIVE_LSB+2:lrp_pkg::LIVE_LSB] = flags;
      end
      lrp_pkg::OFS_MASK: d[lrp_pkg::NEVT-1:0] = mask;
      default: d = 32'h0000_0000;
    endcase
    return d;
  endfunction

  // Zero wait states: answer registered in the setup cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end
    else
    begin
      pready <= setup;
      pslverr <= setup & ~mapped;
      prdata <= (setup && !pwrite) ? read_word(paddr) : 32'h0000_0000;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      permit <= 1'b0;
      gate_en <= 1'b0;
      width <= lrp_pkg::WIDTH_RST;
      period <= lrp_pkg::PERIOD_RST;
      mask <= '0;
    end
    else if (wr)
    begin
      case (paddr)
        lrp_pkg::OFS_CTRL:
        begin
          permit <= pwdata[lrp_pkg::CTRL_PERMIT];
          gate_en <= pwdata[lrp_pkg::CTRL_GATE_EN];
        end
        lrp_pkg::OFS_WIDTH: width <= pwdata[15:0];
        lrp_pkg::OFS_PERIOD: period <= pwdata[15:0];
        lrp_pkg::OFS_MASK: mask <= pwdata[lrp_pkg::NEVT-1:0];
        default: mask <= mask;
      endcase
    end
  end

  // fault clear: release permit, then reassert
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      clr_busy <= 1'b0;
      clr_cnt <= '0;
    end
    else if (clr_start && !clr_busy)
    begin
      clr_busy <= 1'b1;
      clr_cnt <= 16'(RELEASE_CYC - 1);
    end
    else if (clr_end)
      clr_busy <= 1'b0;
    else if (clr_busy)
      clr_cnt <= clr_cnt - 16'h0001;
  end

  // Sticky events; a new event wins over a same-cycle clear
  assign evt = {clr_end, flags[2:1] & ~flags_q[2:1], flags[0] & ~flags_q[0]};
  assign next_status = (wr && paddr == lrp_pkg::OFS_STATUS) ?
                       ((status & ~pwdata[lrp_pkg::NEVT-1:0]) | evt) : (status | evt);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      status <= '0;
      irq <= 1'b0;
    end
    else
    begin
      status <= next_status;
      irq <= |(next_status & mask);
    end
  end

  // ----------------------------------------------------------------
  // Pulse generator and permit line
  // ----------------------------------------------------------------
  logic [15:0] phase;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      phase <= '0;
    else if (!gate_en || phase + 16'h0001 >= period)
      phase <= '0;
    else
      phase <= phase + 16'h0001;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      link.output_gate_pulse <= 1'b0;
      link.run_permit_clear <= 1'b0;
    end
    else
    begin
      // average power set by width and period
      link.output_gate_pulse <= gate_en && permit && phase < width;
      link.run_permit_clear <= permit & ~clr_busy;
    end
  end
endmodule

// ===== tb/lrp_assertions.sv
// Concurrent checks on the real-time link between controller and supervisor
`timescale 1ns/100ps
module lrp_assertions
#(
  parameter int CHECK_CYC = 8,
  parameter int RELEASE_CYC = 4
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic output_gate_pulse,
  input wire logic run_permit_clear,
  input wire logic latched_stop_flag,
  input wire logic pulse_excess_flag,
  input wire logic reflected_power_flag
);
  logic [7:0] up_cnt;
  logic [7:0] low_cnt;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // ----------------------------------------------------------------
  // Helper counters, saturating so long runs never wrap
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      up_cnt <= 8'h00;
    else if (up_cnt != 8'hFF)
      up_cnt <= up_cnt + 8'h01;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      low_cnt <= 8'h00;
    else if (run_permit_clear)
      low_cnt <= 8'h00;
    else if (low_cnt != 8'hFF)
      low_cnt <= low_cnt + 8'h01;
  end

  // ----------------------------------------------------------------
  // Link properties
  // ----------------------------------------------------------------
  sequence gate_idle;
    !output_gate_pulse [*8];
  endsequence
  sequence permit_held;
    run_permit_clear [*8];
  endsequence
  sequence permit_gone;
    !run_permit_clear [*8];
  endsequence
  sequence stop_held;
    latched_stop_flag [*8];
  endsequence

  excess_gate_a: assert property (gate_idle |-> !pulse_excess_flag)
    else $error("excess flag high with gate idle");
  refl_gate_a: assert property (gate_idle |-> !reflected_power_flag)
    else $error("reflected flag high with gate idle");
  stop_hold_a: assert property ((permit_held ##0 latched_stop_flag) |=> latched_stop_flag)
    else $error("stop flag dropped without permit toggle");
  clear_toggle_a: assert property ($fell(latched_stop_flag) |->
    run_permit_clear && !$past(run_permit_clear, 8))
    else $error("stop flag fell without recent permit release");
  powerup_quiet_a: assert property ((up_cnt < CHECK_CYC) |->
    !latched_stop_flag && !pulse_excess_flag)
    else $error("outputs active during power-up check");
  release_len_a: assert property ($rose(run_permit_clear) |-> low_cnt >= RELEASE_CYC)
    else $error("permit release too short");
  latch_quiet_a: assert property (stop_held |->
    !pulse_excess_flag && !reflected_power_flag)
    else $error("warning flag active while latched");
  permit_quiet_a: assert property (permit_gone |->
    !pulse_excess_flag && !reflected_power_flag)
    else $error("warning flag active without permit");
endmodule

// ===== tb/laser_run_permit_fault_supervisor_tb_top.sv
// Bench for controller and supervisor joined over the real-time link
`timescale 1ns/100ps
`define CHK(nm, exp, got) \
  begin \
    samples_checked++; \
    if ((got) !== (exp)) \
    begin \
      err_count++; \
      $display("mismatch %s exp %0h got %0h", nm, exp, got); \
    end \
  end
module laser_run_permit_fault_supervisor_tb_top;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic irq;
  logic overtemp = 1'b0;
  logic shutter = 1'b0;
  logic refl = 1'b0;
  logic terminal = 1'b0;
  logic laser_out;
  logic run_active;
  logic [31:0] rd;
  logic slverr;
  int err_count = 0;
  int samples_checked = 0;
  int gcnt;
  int lcnt;
  logic [7:0] ra [5] = '{8'h04, 8'h08, 8'h10, 8'h0C, 8'h14};
  logic [31:0] rv [5] = '{32'h0000_0000, 32'h0000_0064, 32'h0000_0000,
    32'h0000_0000, 32'h0000_0000};

  always #25 pclk = ~pclk;

  lrp_link_if link();
  lrp_device #(.CHECK_CYC(8)) lrp_device_i (.pclk(pclk), .presetn(presetn), .link(link),
    .overtemp_in(overtemp), .shutter_in(shutter), .refl_high_in(refl),
    .terminal_in(terminal), .laser_out(laser_out), .run_active(run_active));
  lrp_ctrl #(.RELEASE_CYC(4)) lrp_ctrl_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq), .link(link));
  lrp_assertions #(.CHECK_CYC(8), .RELEASE_CYC(4)) lrp_assertions_i (.pclk(pclk),
    .presetn(presetn), .output_gate_pulse(link.output_gate_pulse),
    .run_permit_clear(link.run_permit_clear), .latched_stop_flag(link.latched_stop_flag),
    .pulse_excess_flag(link.pulse_excess_flag),
    .reflected_power_flag(link.reflected_power_flag));

  // ----------------------------------------------------------------
  // Access tasks
  // ----------------------------------------------------------------
  task automatic end_of_test();
    $display("checks %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Ends one edge after release so back-to-back calls never collide
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    for (n = 0; pready !== 1'b1; n++)
    begin
      if (n == 20)
      begin
        err_count++;
        end_of_test();
      end
      @(posedge pclk);
    end
    rd = prdata;
    slverr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  function automatic logic sig(input int s);
    case (s)
      0: return link.latched_stop_flag;
      1: return link.pulse_excess_flag;
      2: return link.reflected_power_flag;
      default: return run_active;
    endcase
  endfunction

  task automatic wait_for(input int s, input logic v, input int lim);
    int n;
    for (n = 0; sig(s) !== v; n++)
    begin
      if (n == lim)
      begin
        err_count++;
        end_of_test();
      end
      @(posedge pclk);
    end
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 5; i++)
    begin
      apb(1'b0, ra[i], 32'h0000_0000);
      `CHK("reg", rv[i], rd)
      `CHK("slverr", (i == 4), slverr)
    end
    `CHK("stop_pwrup", 1'b0, link.latched_stop_flag)
    apb(1'b1, 8'h10, 32'h0000_000F);
    apb(1'b1, 8'h04, 32'h0000_0003);
    apb(1'b1, 8'h08, 32'h0000_0008);
    apb(1'b1, 8'h00, 32'h0000_0005);
    wait_for(3, 1'b1, 50);
    repeat (16) @(posedge pclk);
    gcnt = 0;
    lcnt = 0;
    repeat (16)
    begin
      @(posedge pclk);
      gcnt += int'(link.output_gate_pulse);
      lcnt += int'(laser_out);
    end
    `CHK("gate_cnt", 6, gcnt)
    `CHK("laser_cnt", 6, lcnt)
    // Width equal to period keeps the gate high until the limit bites
    apb(1'b1, 8'h04, 32'h0000_0008);
    wait_for(1, 1'b1, 3000);
    `CHK("run_excess", 1'b1, run_active)
    `CHK("stop_excess", 1'b0, link.latched_stop_flag)
    apb(1'b1, 8'h04, 32'h0000_0001);
    repeat (20) @(posedge pclk);
    apb(1'b0, 8'h0C, 32'h0000_0000);
    `CHK("excess_evt", 1'b1, rd[1])
    `CHK("irq_on", 1'b1, irq)
    apb(1'b1, 8'h10, 32'h0000_0000);
    // Irq is registered from the mask, so it drops one edge after the write lands
    @(posedge pclk);
    `CHK("irq_masked", 1'b0, irq)
    apb(1'b1, 8'h0C, 32'h0000_000F);
    apb(1'b1, 8'h10, 32'h0000_000F);
    `CHK("irq_clear", 1'b0, irq)
    apb(1'b1, 8'h04, 32'h0000_0004);
    refl <= 1'b1;
    wait_for(2, 1'b1, 40);
    `CHK("run_refl", 1'b1, run_active)
    `CHK("stop_refl", 1'b0, link.latched_stop_flag)
    refl <= 1'b0;
    wait_for(2, 1'b0, 40);
    for (int s = 0; s < 2; s++)
    begin
      overtemp <= (s == 0);
      shutter <= (s == 1);
      wait_for(0, 1'b1, 10);
      `CHK("laser_latch", 1'b0, laser_out)
      apb(1'b1, 8'h00, 32'h0000_0007);
      repeat (30) @(posedge pclk);
      `CHK("stop_refused", 1'b1, link.latched_stop_flag)
      overtemp <= 1'b0;
      shutter <= 1'b0;
      repeat (20) @(posedge pclk);
      `CHK("stop_no_toggle", 1'b1, link.latched_stop_flag)
      `CHK("run_no_toggle", 1'b0, run_active)
      apb(1'b1, 8'h00, 32'h0000_0007);
      wait_for(0, 1'b0, 40);
      wait_for(3, 1'b1, 20);
      apb(1'b0, 8'h0C, 32'h0000_0000);
      `CHK("stop_evt", 1'b1, rd[0])
      `CHK("clear_done", 1'b1, rd[3])
      `CHK("refl_evt", (s == 0), rd[2])
      apb(1'b1, 8'h0C, 32'h0000_000F);
    end
    terminal <= 1'b1;
    presetn <= 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    wait_for(0, 1'b1, 40);
    apb(1'b1, 8'h00, 32'h0000_0005);
    repeat (20) @(posedge pclk);
    `CHK("run_term", 1'b0, run_active)
    `CHK("laser_term", 1'b0, laser_out)
    end_of_test();
  end
endmodule
